// *** rtl/dma_channel_regs.sv ***
// Eight-channel DMA address, count and collision status block with an AHB-Lite slave.
// Summary of operation
// RULE_01 - Each channel has a 16-bit read/write primary RAM base address.
// RULE_02 - Each channel has a 16-bit read/write alternate RAM base address.
// RULE_03 - Each channel has a 16-bit read/write peripheral target address.
// RULE_04 - Software avoids writing peripheral address or count while the channel runs.
// RULE_05 - Count holds ten writable bits; bits fifteen to ten read zero.
// RULE_06 - A block moves count plus one transfers; zero count gives one.
// RULE_07 - Status bit 8+n flags a peripheral write collision of channel n.
// RULE_08 - Status bit n flags a RAM write collision of channel n.
// RULE_09 - All address, count and collision bits are zero after reset.
// RULE_10 - A per-channel enable activates the channel.
// RULE_11 - Ping-pong mode alternates primary and alternate bases on successive blocks.
// RULE_12 - Buffer select status reads one while the alternate base is used.
// RULE_13 - Collision flags stay set until software clears them.
// RULE_14 - All sixteen collision flags read as one word.
`timescale 1ns/1ns
`include "dma_chan_map.svh"
module dma_channel_regs #(
  parameter int NUM_CH = `DMA_NUM_CH,
  parameter int ADDR_W = `DMA_ADDR_W,
  parameter int COUNT_W = `DMA_COUNT_W
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Interrupt
  output logic IRQ,
  // Peripheral requests and collision reports
  input wire logic [NUM_CH-1:0] DMA_REQ,
  input wire logic [NUM_CH-1:0] PERIPH_COLLISION,
  input wire logic [NUM_CH-1:0] RAM_COLLISION,
  // Transfer issue
  output logic XFER_VALID,
  output logic [2:0] XFER_CHAN,
  output logic [ADDR_W-1:0] XFER_RAM_ADDR,
  output logic [ADDR_W-1:0] XFER_PERIPH_ADDR,
  output logic XFER_TO_PERIPH,
  input wire logic XFER_ACK
);

  // ========================================================================
  // Declarations
  logic rst_meta;
  logic rst_n;
  logic d_valid;
  logic d_write;
  logic d_read;
  logic [11:0] d_addr;
  logic [2:0] d_ch;
  logic d_ch_region;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_value;
  logic [ADDR_W-1:0] primary [NUM_CH];
  logic [ADDR_W-1:0] alternate [NUM_CH];
  logic [ADDR_W-1:0] periph [NUM_CH];
  logic [COUNT_W-1:0] count [NUM_CH];
  logic [NUM_CH-1:0] enable;
  logic [NUM_CH-1:0] to_periph;
  logic [NUM_CH-1:0] pingpong;
  logic [NUM_CH-1:0] oneshot;
  logic [NUM_CH-1:0] pending;
  logic [NUM_CH-1:0] chan_ack;
  logic [NUM_CH-1:0] buf_sel;
  logic [NUM_CH-1:0] block_done;
  logic [NUM_CH-1:0] stop;
  logic [ADDR_W-1:0] ch_ram_addr [NUM_CH];
  logic [15:0] coll_flags;
  logic [15:0] coll_set;
  logic coll_clear;
  logic [15:0] irq_mask;
  logic pick_found;
  logic [2:0] pick_ch;
  dma_chan_pkg::xfer_state_e xfer_state;

  // ========================================================================
  // Reset release
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ========================================================================
  // Bus slave: writes finish without wait, reads take one wait state so a
  // read that follows a write sees the written value.
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      d_valid <= 1'b0;
      d_write <= 1'b0;
      d_addr <= 12'h000;
    end else if (HREADY) begin
      d_valid <= HSEL && HTRANS[1];
      d_write <= HWRITE;
      d_addr <= HADDR[11:0];
    end
  end

  assign d_read = d_valid && !d_write;
  assign wr_fire = d_valid && d_write;
  assign rd_fire = d_read && !HREADYOUT;
  assign d_ch = d_addr[7:5];
  assign d_ch_region = (d_addr[11:8] == 4'h0);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h00000000;
      HRESP <= 1'b0;
    end else if (rd_fire) begin
      HREADYOUT <= 1'b1;
      HRDATA <= rd_value;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HREADYOUT <= 1'b0;
    end
  end

  // ========================================================================
  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_value = 32'h00000000;
    if (d_ch_region) begin
      case (d_addr[4:0])
        `DMA_OFS_CTRL: begin
          rd_value[`DMA_CTRL_ENABLE_BIT] = enable[d_ch];
          rd_value[`DMA_CTRL_TO_PERIPH_BIT] = to_periph[d_ch];
          rd_value[`DMA_CTRL_PINGPONG_BIT] = pingpong[d_ch];
          rd_value[`DMA_CTRL_ONESHOT_BIT] = oneshot[d_ch];
        end
        `DMA_OFS_PRIMARY: rd_value[ADDR_W-1:0] = primary[d_ch]; // RULE_01
        `DMA_OFS_ALTERNATE: rd_value[ADDR_W-1:0] = alternate[d_ch]; // RULE_02
        `DMA_OFS_PERIPH: rd_value[ADDR_W-1:0] = periph[d_ch]; // RULE_03
        `DMA_OFS_COUNT: rd_value[COUNT_W-1:0] = count[d_ch]; // RULE_05
        default: rd_value = 32'h00000000;
      endcase
    end else begin
      case (d_addr)
        `DMA_OFS_COLLISION: rd_value[15:0] = coll_flags; // RULE_14
        `DMA_OFS_BUFSEL: rd_value[NUM_CH-1:0] = buf_sel; // RULE_12
        `DMA_OFS_MASK: rd_value[15:0] = irq_mask;
        default: rd_value = 32'h00000000;
      endcase
    end
  end

  // ========================================================================
  // Channel address and count registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        primary[i] <= `DMA_WORD_RESET; // RULE_09
        alternate[i] <= `DMA_WORD_RESET;
        periph[i] <= `DMA_WORD_RESET;
        count[i] <= `DMA_COUNT_RESET;
      end
    end else if (wr_fire && d_ch_region) begin
      // Writes while the channel runs are taken as given; keeping them out is
      // left to software.
      case (d_addr[4:0])
        `DMA_OFS_PRIMARY: primary[d_ch] <= HWDATA[ADDR_W-1:0]; // RULE_01
        `DMA_OFS_ALTERNATE: alternate[d_ch] <= HWDATA[ADDR_W-1:0]; // RULE_02
        `DMA_OFS_PERIPH: periph[d_ch] <= HWDATA[ADDR_W-1:0]; // RULE_03 RULE_04
        `DMA_OFS_COUNT: count[d_ch] <= HWDATA[COUNT_W-1:0]; // RULE_05 RULE_04
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Channel control; a one-shot stop wins over a software write
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      enable <= `DMA_BYTE_RESET;
      to_periph <= `DMA_BYTE_RESET;
      pingpong <= `DMA_BYTE_RESET;
      oneshot <= `DMA_BYTE_RESET;
    end else begin
      if (wr_fire && d_ch_region && d_addr[4:0] == `DMA_OFS_CTRL) begin
        enable[d_ch] <= HWDATA[`DMA_CTRL_ENABLE_BIT]; // RULE_10
        to_periph[d_ch] <= HWDATA[`DMA_CTRL_TO_PERIPH_BIT];
        pingpong[d_ch] <= HWDATA[`DMA_CTRL_PINGPONG_BIT];
        oneshot[d_ch] <= HWDATA[`DMA_CTRL_ONESHOT_BIT];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (stop[i]) begin
          enable[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `DMA_WORD_RESET;
    end else if (wr_fire && d_addr == `DMA_OFS_MASK) begin
      irq_mask <= HWDATA[15:0];
    end
  end

  // ========================================================================
  // Channel engines
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    dma_channel_engine #(
      .COUNT_W(COUNT_W),
      .ADDR_W(ADDR_W)
    ) u_engine (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .enable(enable[g]),
      .pingpong(pingpong[g]),
      .oneshot(oneshot[g]),
      .count(count[g]),
      .primary(primary[g]),
      .alternate(alternate[g]),
      .xfer_ack(chan_ack[g]),
      .ram_addr(ch_ram_addr[g]),
      .buf_sel(buf_sel[g]),
      .block_done(block_done[g]),
      .stop(stop[g])
    );
  end

  // ========================================================================
  // Request capture and fixed-priority pick; a request in the issue cycle is kept
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pending <= `DMA_BYTE_RESET;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!enable[i]) begin
          pending[i] <= 1'b0; // RULE_10
        end else if (DMA_REQ[i]) begin
          pending[i] <= 1'b1;
        end else if (xfer_state == dma_chan_pkg::XFER_IDLE && pick_found && pick_ch == 3'(i)) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    pick_found = 1'b0;
    pick_ch = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i] && enable[i]) begin
        pick_found = 1'b1;
        pick_ch = 3'(i);
      end
    end
  end

  // ========================================================================
  // Transfer issue; the request stands until the far side acknowledges it
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      xfer_state <= dma_chan_pkg::XFER_IDLE;
      XFER_VALID <= 1'b0;
      XFER_CHAN <= 3'h0;
      XFER_RAM_ADDR <= `DMA_WORD_RESET;
      XFER_PERIPH_ADDR <= `DMA_WORD_RESET;
      XFER_TO_PERIPH <= 1'b0;
      chan_ack <= `DMA_BYTE_RESET;
    end else begin
      chan_ack <= `DMA_BYTE_RESET;
      case (xfer_state)
        dma_chan_pkg::XFER_IDLE: begin
          if (pick_found) begin
            XFER_VALID <= 1'b1;
            XFER_CHAN <= pick_ch;
            XFER_RAM_ADDR <= ch_ram_addr[pick_ch]; // RULE_11
            XFER_PERIPH_ADDR <= periph[pick_ch]; // RULE_03
            XFER_TO_PERIPH <= to_periph[pick_ch];
            xfer_state <= dma_chan_pkg::XFER_WAIT;
          end
        end
        dma_chan_pkg::XFER_WAIT: begin
          if (XFER_ACK) begin
            XFER_VALID <= 1'b0;
            chan_ack[XFER_CHAN] <= 1'b1; // RULE_06
            xfer_state <= dma_chan_pkg::XFER_IDLE;
          end
        end
        default: xfer_state <= dma_chan_pkg::XFER_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Collision flags and interrupt; a read of the flags clears them
  assign coll_set = {PERIPH_COLLISION, RAM_COLLISION}; // RULE_07 RULE_08
  assign coll_clear = rd_fire && d_addr == `DMA_OFS_COLLISION; // RULE_13

  sticky_flags #(
    .WIDTH(16)
  ) u_coll (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .set(coll_set),
    .clear(coll_clear),
    .flags(coll_flags)
  );

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(coll_flags & irq_mask);
    end
  end

  // ========================================================================
  // Checks
  chk_read_wait: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    HREADY && HSEL && HTRANS[1] && !HWRITE && HREADYOUT |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read did not take exactly one wait state");

  chk_count_upper: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_05
    rd_fire && d_ch_region && d_addr[4:0] == `DMA_OFS_COUNT |=> HRDATA[31:COUNT_W] == '0)
    else $error("count register upper bits not zero");

  chk_periph_flag_set: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_07
    PERIPH_COLLISION[0] |=> coll_flags[`DMA_COLL_PERIPH_LSB])
    else $error("peripheral collision flag not set");

  chk_ram_flag_set: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_08
    RAM_COLLISION[NUM_CH-1] |=> coll_flags[`DMA_COLL_RAM_LSB + NUM_CH - 1])
    else $error("RAM collision flag not set");

  chk_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_13
    !coll_clear |=> (coll_flags & $past(coll_flags)) == $past(coll_flags))
    else $error("collision flag dropped without a read");

  chk_irq_level: assert property (@(posedge CORE_CLK) disable iff (!rst_n)
    ##1 IRQ == |($past(coll_flags) & $past(irq_mask)))
    else $error("interrupt level does not follow masked flags");

  chk_xfer_hold: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_11
    XFER_VALID && !XFER_ACK |=> XFER_VALID && $stable(XFER_RAM_ADDR) && $stable(XFER_CHAN))
    else $error("transfer request changed before acknowledge");

  chk_enable_gate: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE_10
    $rose(XFER_VALID) |-> 1'($past(enable) >> XFER_CHAN))
    else $error("transfer issued for a disabled channel");

  cov_collision_clear: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    coll_clear && coll_flags != 16'h0000);

  cov_pingpong_block: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    |(block_done & pingpong & buf_sel));

  cov_oneshot_stop: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    |stop);

endmodule : dma_channel_regs

// *** rtl/dma_chan_map.svh ***
// Register offsets, field positions, reset values and widths of the DMA channel block.
`ifndef DMA_CHAN_MAP_SVH
`define DMA_CHAN_MAP_SVH

// ==========================================================================
// Sizes
`define DMA_NUM_CH 8
`define DMA_ADDR_W 16
`define DMA_COUNT_W 10

// ==========================================================================
// Per-channel block: byte address = channel * stride + register offset
`define DMA_CH_STRIDE 12'h020
`define DMA_OFS_CTRL 5'h00
`define DMA_OFS_PRIMARY 5'h04
`define DMA_OFS_ALTERNATE 5'h08
`define DMA_OFS_PERIPH 5'h0C
`define DMA_OFS_COUNT 5'h10

// ==========================================================================
// Shared registers
`define DMA_OFS_COLLISION 12'h100
`define DMA_OFS_BUFSEL 12'h104
`define DMA_OFS_MASK 12'h108

// ==========================================================================
// Control fields
`define DMA_CTRL_ENABLE_BIT 15
`define DMA_CTRL_TO_PERIPH_BIT 13
`define DMA_CTRL_PINGPONG_BIT 1
`define DMA_CTRL_ONESHOT_BIT 0

// ==========================================================================
// Collision layout and reset values
`define DMA_COLL_PERIPH_LSB 8
`define DMA_COLL_RAM_LSB 0
`define DMA_WORD_RESET 16'h0000
`define DMA_COUNT_RESET 10'h000
`define DMA_BYTE_RESET 8'h00

`endif

// *** rtl/dma_chan_pkg.sv ***
// Types shared by the DMA channel block.
package dma_chan_pkg;

  // ========================================================================
  // Transfer issue states
  typedef enum logic [0:0] {
    XFER_IDLE,
    XFER_WAIT
  } xfer_state_e;

  typedef logic [15:0] word_t;

endpackage : dma_chan_pkg

// *** rtl/sticky_flags.sv ***
// Sticky event flags with a common clear in which a new event wins.
`timescale 1ns/1ns
module sticky_flags #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events and clear
  input wire logic [WIDTH-1:0] set,
  input wire logic clear,
  // Flags
  output logic [WIDTH-1:0] flags
);

  // ========================================================================
  // Flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= (clear ? '0 : flags) | set; // RULE_13
    end
  end

endmodule : sticky_flags

// *** rtl/dma_channel_engine.sv ***
// Block position, buffer alternation and block end of one DMA channel.
`timescale 1ns/1ns
module dma_channel_engine #(
  parameter int COUNT_W = 10,
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel setup
  input wire logic enable,
  input wire logic pingpong,
  input wire logic oneshot,
  input wire logic [COUNT_W-1:0] count,
  input wire logic [ADDR_W-1:0] primary,
  input wire logic [ADDR_W-1:0] alternate,
  // Transfer progress
  input wire logic xfer_ack,
  output logic [ADDR_W-1:0] ram_addr,
  output logic buf_sel,
  output logic block_done,
  output logic stop
);

  logic [COUNT_W-1:0] position;
  logic last;
  logic [COUNT_W:0] acks_seen;

  // ========================================================================
  // Address generation
  assign last = (position == count); // RULE_06
  assign ram_addr = ADDR_W'((buf_sel ? alternate : primary) + ADDR_W'(position)); // RULE_01 RULE_02

  // ========================================================================
  // Position within the block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      position <= '0;
    end else if (!enable) begin
      position <= '0; // RULE_10
    end else if (xfer_ack) begin
      position <= last ? '0 : COUNT_W'(position + 1'b1); // RULE_06
    end
  end

  // ========================================================================
  // Buffer alternation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_sel <= 1'b0;
    end else if (!enable) begin
      buf_sel <= 1'b0;
    end else if (xfer_ack && last && pingpong) begin
      buf_sel <= ~buf_sel; // RULE_11 RULE_12
    end
  end

  // ========================================================================
  // Block end and one-shot stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_done <= 1'b0;
      stop <= 1'b0;
    end else begin
      block_done <= enable && xfer_ack && last;
      // In ping-pong one-shot mode each buffer is filled once before stopping.
      stop <= enable && xfer_ack && last && oneshot && (!pingpong || buf_sel);
    end
  end

  // ========================================================================
  // Checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acks_seen <= '0;
    end else if (!enable || block_done) begin
      acks_seen <= '0;
    end else if (xfer_ack) begin
      acks_seen <= (COUNT_W+1)'(acks_seen + 1'b1);
    end
  end

  chk_block_length: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    block_done |-> acks_seen == (COUNT_W+1)'({1'b0, count} + 1'b1))
    else $error("block length differs from count plus one");

  chk_pingpong_swap: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    block_done && $past(pingpong) |-> buf_sel != $past(buf_sel))
    else $error("buffer select did not alternate at block end");

endmodule : dma_channel_engine

// *** sim/xfer_partner.sv ***
// Behavioural far side that acknowledges each issued transfer after a set wait.
`timescale 1ns/1ns
module xfer_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Transfer link
  input wire logic xfer_valid,
  input wire logic [3:0] wait_cyc,
  output logic xfer_ack
);
  // ==========================================================================
  // Acknowledge
  logic [3:0] cnt;
  // The ack drops at the edge that takes it, so one transfer never sees two.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (xfer_ack) begin
      xfer_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (xfer_valid) begin
      if (cnt >= wait_cyc) begin
        xfer_ack <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : xfer_partner

// *** sim/tb_dma_channel_address_count_status.sv ***
// Testbench of the DMA channel address, count and collision block.
`timescale 1ns/1ns
`include "dma_chan_map.svh"
module tb_dma_channel_address_count_status;
  // ==========================================================================
  // Signals
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic IRQ;
  logic [7:0] DMA_REQ = 8'h00;
  logic [7:0] PERIPH_COLLISION = 8'h00;
  logic [7:0] RAM_COLLISION = 8'h00;
  logic XFER_VALID;
  logic [2:0] XFER_CHAN;
  logic [15:0] XFER_RAM_ADDR;
  logic [15:0] XFER_PERIPH_ADDR;
  logic XFER_TO_PERIPH;
  logic XFER_ACK;
  logic [3:0] wait_cyc = 4'h0;
  logic [31:0] rd;
  int err_count = 0;
  int checks_done = 0;

  always #10 CORE_CLK = ~CORE_CLK;

  dma_channel_regs dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
    .DMA_REQ(DMA_REQ), .PERIPH_COLLISION(PERIPH_COLLISION), .RAM_COLLISION(RAM_COLLISION),
    .XFER_VALID(XFER_VALID), .XFER_CHAN(XFER_CHAN), .XFER_RAM_ADDR(XFER_RAM_ADDR),
    .XFER_PERIPH_ADDR(XFER_PERIPH_ADDR), .XFER_TO_PERIPH(XFER_TO_PERIPH),
    .XFER_ACK(XFER_ACK));

  xfer_partner model (.clk(CORE_CLK), .rst_n(RESET_N), .xfer_valid(XFER_VALID),
    .wait_cyc(wait_cyc), .xfer_ack(XFER_ACK));

  // ==========================================================================
  // Tasks
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; hready is sampled at each following edge.
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {20'h00000, a};
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    chk({31'h0, HRESP}, 32'h0);
  endtask : ahb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  function automatic logic [11:0] ra(input int ch, input logic [4:0] ofs);
    return 12'(ch) * `DMA_CH_STRIDE + {7'h00, ofs};
  endfunction : ra

  task automatic xfer(input int ch, input logic [15:0] ram, input logic [15:0] per,
                      input logic dir);
    DMA_REQ <= 8'h01 << ch;
    @(posedge CORE_CLK);
    DMA_REQ <= 8'h00;
    do @(posedge CORE_CLK); while (XFER_VALID !== 1'b1);
    chk({16'h0, XFER_RAM_ADDR}, {16'h0, ram});
    chk({XFER_TO_PERIPH, 12'h0, XFER_CHAN, XFER_PERIPH_ADDR}, {dir, 12'h0, 3'(ch), per});
    do @(posedge CORE_CLK); while (XFER_VALID === 1'b1);
  endtask : xfer

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    test_done();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    for (int n = 0; n < 8; n++) begin
      for (int r = 1; r < 5; r++) rdc(ra(n, 5'(4 * r)), 32'h0);
    end
    rdc(`DMA_OFS_COLLISION, 32'h0);
    rdc(12'h200, 32'h0);
    for (int n = 0; n < 8; n++) begin
      ahb(1'b1, ra(n, `DMA_OFS_PRIMARY), 32'hFFFF_A55A ^ 32'(n));
      ahb(1'b1, ra(n, `DMA_OFS_ALTERNATE), 32'hFFFF_5AA5 ^ 32'(n));
      ahb(1'b1, ra(n, `DMA_OFS_PERIPH), 32'hFFFF_FFFF);
      ahb(1'b1, ra(n, `DMA_OFS_COUNT), 32'hFFFF_FFFF);
      rdc(ra(n, `DMA_OFS_PRIMARY), 32'h0000_A55A ^ 32'(n));
      rdc(ra(n, `DMA_OFS_ALTERNATE), 32'h0000_5AA5 ^ 32'(n));
      rdc(ra(n, `DMA_OFS_PERIPH), 32'h0000_FFFF);
      rdc(ra(n, `DMA_OFS_COUNT), 32'h0000_03FF);
    end
    // Four ping-pong blocks of three on channel 2, with answer waits of 0, 2, 4 and 6.
    ahb(1'b1, ra(2, `DMA_OFS_PRIMARY), 32'h0100);
    ahb(1'b1, ra(2, `DMA_OFS_ALTERNATE), 32'h0200);
    ahb(1'b1, ra(2, `DMA_OFS_PERIPH), 32'h0300);
    ahb(1'b1, ra(2, `DMA_OFS_COUNT), 32'h0002);
    ahb(1'b1, ra(2, `DMA_OFS_CTRL), 32'hA002);
    for (int b = 0; b < 4; b++) begin
      wait_cyc <= 4'(b * 2);
      for (int i = 0; i < 3; i++) begin
        xfer(2, ((b % 2) ? 16'h0200 : 16'h0100) + 16'(i), 16'h0300, 1'b1);
      end
      rdc(`DMA_OFS_BUFSEL, (b % 2) ? 32'h0 : 32'h4);
    end
    ahb(1'b1, ra(2, `DMA_OFS_CTRL), 32'h0000);
    // One-shot with a zero count stops after a single transfer.
    ahb(1'b1, ra(5, `DMA_OFS_PRIMARY), 32'h0400);
    ahb(1'b1, ra(5, `DMA_OFS_COUNT), 32'h0000);
    ahb(1'b1, ra(5, `DMA_OFS_CTRL), 32'h8001);
    xfer(5, 16'h0400, 16'hFFFF, 1'b0);
    ahb(1'b0, ra(5, `DMA_OFS_CTRL), 32'h0);
    chk({31'h0, rd[15]}, 32'h0);
    // Ping-pong one-shot fills each buffer once and then stops.
    ahb(1'b1, ra(4, `DMA_OFS_PRIMARY), 32'h0500);
    ahb(1'b1, ra(4, `DMA_OFS_ALTERNATE), 32'h0600);
    ahb(1'b1, ra(4, `DMA_OFS_COUNT), 32'h0000);
    ahb(1'b1, ra(4, `DMA_OFS_CTRL), 32'h8003);
    xfer(4, 16'h0500, 16'hFFFF, 1'b0);
    xfer(4, 16'h0600, 16'hFFFF, 1'b0);
    ahb(1'b0, ra(4, `DMA_OFS_CTRL), 32'h0);
    chk(rd, 32'h0000_0003);
    DMA_REQ <= 8'h38;
    @(posedge CORE_CLK);
    DMA_REQ <= 8'h00;
    repeat (4) @(posedge CORE_CLK);
    chk({31'h0, XFER_VALID}, 32'h0);
    // Collision flags of every channel, raised, held and cleared by a read.
    ahb(1'b1, `DMA_OFS_MASK, 32'hFFFF);
    rdc(`DMA_OFS_MASK, 32'hFFFF);
    for (int n = 0; n < 8; n++) begin
      PERIPH_COLLISION <= 8'h01 << n;
      RAM_COLLISION <= 8'h01 << n;
      @(posedge CORE_CLK);
      PERIPH_COLLISION <= 8'h00;
      RAM_COLLISION <= 8'h00;
      repeat (3) @(posedge CORE_CLK);
      chk({31'h0, IRQ}, 32'h1);
      rdc(`DMA_OFS_COLLISION, 32'h101 << n);
      repeat (2) @(posedge CORE_CLK);
      chk({31'h0, IRQ}, 32'h0);
      rdc(`DMA_OFS_COLLISION, 32'h0);
    end
    ahb(1'b1, `DMA_OFS_MASK, 32'h0);
    RAM_COLLISION <= 8'h08;
    @(posedge CORE_CLK);
    RAM_COLLISION <= 8'h00;
    repeat (3) @(posedge CORE_CLK);
    chk({31'h0, IRQ}, 32'h0);
    rdc(`DMA_OFS_COLLISION, 32'h8);
    test_done();
  end
endmodule : tb_dma_channel_address_count_status
